// ### rtl/cmdx_alu.sv
// Purpose: combinational operation unit for variable arithmetic
// Assumes: operands are signed 32-bit words
// Notes:   a is the destination operand, b the second operand
`timescale 1ns/1ps
`default_nettype none
module cmdx_alu (
    // operation
    input  wire logic [3:0]               op,
    input  wire logic [31:0]              a,
    input  wire logic [31:0]              b,
    // results
    output logic      [31:0]              res,
    output logic                          wr_a,
    output logic                          wr_b,
    output logic                          cmp_valid,
    output logic      [cmdx_pkg::FLAG_W-1:0] cmp_flags
);
    logic signed [31:0] sa;
    logic signed [31:0] sb;
    logic        [63:0] prod;

    assign sa   = a;
    assign sb   = b;
    assign prod = a * b;

    always_comb begin
        res       = a;
        wr_a      = 1'b1;
        wr_b      = 1'b0;
        cmp_valid = 1'b0;
        cmp_flags = '0;
        unique case (op)
            cmdx_pkg::ALU_ADD:  res = a + b;
            cmdx_pkg::ALU_SUB:  res = a - b;
            cmdx_pkg::ALU_MUL:  res = prod[31:0];
            // a is dividend, b divisor
            // divide by zero leaves the destination unchanged
            cmdx_pkg::ALU_DIV:  res = (b == 32'h0000_0000) ? a : 32'(sa / sb);
            cmdx_pkg::ALU_MOD:  res = (b == 32'h0000_0000) ? a : 32'(sa % sb);
            cmdx_pkg::ALU_AND:  res = a & b;
            cmdx_pkg::ALU_OR:   res = a | b;
            cmdx_pkg::ALU_XOR:  res = a ^ b;
            cmdx_pkg::ALU_NOT:  res = ~b;
            cmdx_pkg::ALU_LOAD: res = b;
            cmdx_pkg::ALU_SWAP: begin
                res  = b;
                wr_b = 1'b1;
            end
            cmdx_pkg::ALU_COMP: begin
                wr_a      = 1'b0;
                cmp_valid = 1'b1;
                cmp_flags[cmdx_pkg::FLAG_ZERO] = (a == b);
                cmp_flags[cmdx_pkg::FLAG_LESS] = (sa < sb);
            end
            default: wr_a = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ### rtl/cmdx_pkg.sv
// Purpose: shared constants and types of the command execution unit
// Assumes: byte-wide frame stream on the same clock as the unit
// Notes:   opcodes, status codes and command frame positions live here; reply byte positions are coded in reply_byte
package cmdx_pkg;
    localparam logic [7:0] OP_IRQ_ON      = 8'h19;
    localparam logic [7:0] OP_IRQ_OFF     = 8'h1A;
    localparam logic [7:0] OP_SET_HANDLER = 8'h25;
    localparam logic [7:0] OP_HANDLER_RET = 8'h26;
    localparam logic [7:0] OP_VAR_VAR     = 8'h28;
    localparam logic [7:0] OP_VAR_ACC     = 8'h29;
    localparam logic [7:0] IRQ_ALL        = 8'hFF;

    localparam logic [7:0] STATUS_OK       = 8'h64;
    localparam logic [7:0] STATUS_BAD_CSUM = 8'h01;
    localparam logic [7:0] STATUS_BAD_CMD  = 8'h02;

    localparam logic [7:0] HOST_ADDR_RST   = 8'h02;
    localparam logic [7:0] MODULE_ADDR_RST = 8'h01;

    // byte positions inside a 9-byte frame
    localparam logic [3:0] POS_ADDR   = 4'h0;
    localparam logic [3:0] POS_OP     = 4'h1;
    localparam logic [3:0] POS_TYPE   = 4'h2;
    localparam logic [3:0] POS_BANK   = 4'h3;
    localparam logic [3:0] POS_VAL3   = 4'h4;
    localparam logic [3:0] POS_CSUM   = 4'h8;

    localparam int         FLAG_W     = 2;
    localparam int         FLAG_ZERO  = 0;
    localparam int         FLAG_LESS  = 1;
    localparam logic [31:0] WORD_RST  = 32'h0000_0000;

    typedef enum logic [3:0] {
        ALU_ADD  = 4'h0,
        ALU_SUB  = 4'h1,
        ALU_MUL  = 4'h2,
        ALU_DIV  = 4'h3,
        ALU_MOD  = 4'h4,
        ALU_AND  = 4'h5,
        ALU_OR   = 4'h6,
        ALU_XOR  = 4'h7,
        ALU_NOT  = 4'h8,
        ALU_LOAD = 4'h9,
        ALU_SWAP = 4'hA,
        ALU_COMP = 4'hB
    } cmdx_alu_op_t;

    typedef enum logic [1:0] {
        ST_RX   = 2'b00,
        ST_EXEC = 2'b01,
        ST_TX   = 2'b11
    } cmdx_state_t;
endpackage

// ### rtl/cmdx_unit.sv
// Purpose: command execution unit for handler vectors and variable arithmetic
// Assumes: frame bytes and program commands come from logic on ref_clk
// Notes:   host frames to the unit's address get a reply, program commands get a done pulse
`timescale 1ns/1ps
`default_nettype none
module cmdx_unit #(
    parameter int IRQ_NUM = 32,
    parameter int VAR_NUM = 256
) (
    // clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst_n,
    // host frame in
    input  wire logic [7:0]                    rx_byte,
    input  wire logic                          rx_valid,
    output logic                               rx_ready,
    // reply frame out
    output logic      [7:0]                    tx_byte,
    output logic                               tx_valid,
    input  wire logic                          tx_ready,
    // stored program command
    input  wire logic                          prog_valid,
    input  wire logic [7:0]                    prog_op,
    input  wire logic [7:0]                    prog_type,
    input  wire logic [7:0]                    prog_bank,
    input  wire logic [31:0]                   prog_value,
    output logic                               prog_done,
    // interrupt entry and program counter
    input  wire logic                          irq_take,
    input  wire logic [7:0]                    irq_num,
    input  wire logic [31:0]                   pc_in,
    output logic      [31:0]                   pc_out,
    output logic                               pc_load,
    output logic                               irq_enabled,
    output logic                               in_handler,
    // working registers
    input  wire logic                          acc_wr,
    input  wire logic [31:0]                   acc_wdata,
    input  wire logic                          x_wr,
    input  wire logic [31:0]                   x_wdata,
    output logic      [31:0]                   acc_out,
    output logic      [31:0]                   x_out,
    output logic      [cmdx_pkg::FLAG_W-1:0]   flags_out
);
    cmdx_pkg::cmdx_state_t           state_reg;
    logic [3:0]                      rx_cnt_reg;
    logic [7:0]                      rx_sum_reg;
    logic [7:0]                      op_reg;
    logic [7:0]                      type_reg;
    logic [7:0]                      bank_reg;
    logic [31:0]                     val_reg;
    logic                            from_host_reg;
    logic                            csum_ok_reg;
    logic                            addr_ok_reg;
    logic [7:0]                      status_reg;
    logic [31:0]                     rep_val_reg;
    logic [3:0]                      tx_cnt_reg;
    logic [7:0]                      tx_sum_reg;
    logic [31:0]                     var_reg [VAR_NUM];
    logic [31:0]                     vec_reg [IRQ_NUM];
    logic [31:0]                     sav_acc_reg;
    logic [31:0]                     sav_x_reg;
    logic [31:0]                     sav_pc_reg;
    logic [cmdx_pkg::FLAG_W-1:0]     sav_flags_reg;

    logic [7:0]  idx_a;
    logic [7:0]  idx_b;
    logic        is_vv;
    logic        is_va;
    logic [31:0] opnd_a;
    logic [31:0] opnd_b;
    logic [31:0] alu_res;
    logic        alu_wr_a;
    logic        alu_wr_b;
    logic        alu_cmp;
    logic [cmdx_pkg::FLAG_W-1:0] alu_flags;
    logic        exec_ok;
    logic        exec;
    logic        rx_take;
    logic        tx_step;
    logic        irq_go;

    function automatic logic [7:0] reply_byte(input logic [3:0] pos, input logic [7:0] st,
                                              input logic [7:0] op, input logic [31:0] v);
        logic [7:0] b;
        b = 8'h00;
        unique case (pos)
            4'h0:    b = cmdx_pkg::HOST_ADDR_RST;
            4'h1:    b = cmdx_pkg::MODULE_ADDR_RST;
            4'h2:    b = st;
            4'h3:    b = op;
            4'h4:    b = v[31:24];
            4'h5:    b = v[23:16];
            4'h6:    b = v[15:8];
            default: b = v[7:0];
        endcase
        return b;
    endfunction

    assign idx_a   = bank_reg;
    assign idx_b   = val_reg[7:0];
    assign is_vv   = (op_reg == cmdx_pkg::OP_VAR_VAR);
    assign is_va   = (op_reg == cmdx_pkg::OP_VAR_ACC);
    assign opnd_a  = var_reg[idx_a];
    assign opnd_b  = is_va ? acc_out : var_reg[idx_b];
    assign exec    = (state_reg == cmdx_pkg::ST_EXEC) && csum_ok_reg && addr_ok_reg;
    assign rx_take = rx_valid && rx_ready;
    assign tx_step = tx_valid && tx_ready;
    // entry only with an idle collector, so a partial frame is never split
    assign irq_go  = (state_reg == cmdx_pkg::ST_RX) && irq_take && irq_enabled && !in_handler &&
                     (32'(irq_num) < IRQ_NUM) && (rx_cnt_reg == 4'h0) && !rx_take;
    assign exec_ok = (is_vv || is_va) ? (type_reg <= 8'(cmdx_pkg::ALU_COMP)) :
                     (op_reg == cmdx_pkg::OP_SET_HANDLER) || (op_reg == cmdx_pkg::OP_HANDLER_RET) ||
                     (op_reg == cmdx_pkg::OP_IRQ_ON) || (op_reg == cmdx_pkg::OP_IRQ_OFF);

    cmdx_alu u_alu (
        .op        (type_reg[3:0]),
        .a         (opnd_a),
        .b         (opnd_b),
        .res       (alu_res),
        .wr_a      (alu_wr_a),
        .wr_b      (alu_wr_b),
        .cmp_valid (alu_cmp),
        .cmp_flags (alu_flags)
    );

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg     <= cmdx_pkg::ST_RX;
            rx_cnt_reg    <= 4'h0;
            rx_sum_reg    <= 8'h00;
            op_reg        <= 8'h00;
            type_reg      <= 8'h00;
            bank_reg      <= 8'h00;
            val_reg       <= cmdx_pkg::WORD_RST;
            from_host_reg <= 1'b0;
            csum_ok_reg   <= 1'b0;
            addr_ok_reg   <= 1'b0;
            rx_ready      <= 1'b0;
        end else begin
            unique case (state_reg)
                cmdx_pkg::ST_RX: begin
                    rx_ready <= 1'b1;
                    if (rx_take) begin
                        rx_sum_reg <= rx_sum_reg + rx_byte;
                        rx_cnt_reg <= rx_cnt_reg + 4'h1;
                        unique case (rx_cnt_reg)
                            cmdx_pkg::POS_ADDR: addr_ok_reg <= (rx_byte == cmdx_pkg::MODULE_ADDR_RST);
                            cmdx_pkg::POS_OP:   op_reg      <= rx_byte;
                            cmdx_pkg::POS_TYPE: type_reg    <= rx_byte;
                            cmdx_pkg::POS_BANK: bank_reg    <= rx_byte;
                            cmdx_pkg::POS_CSUM: csum_ok_reg <= (rx_byte == rx_sum_reg);
                            default:            val_reg     <= {val_reg[23:0], rx_byte};
                        endcase
                        if (rx_cnt_reg == cmdx_pkg::POS_CSUM) begin
                            from_host_reg <= 1'b1;
                            rx_ready      <= 1'b0;
                            state_reg     <= cmdx_pkg::ST_EXEC;
                        end
                    end else if (prog_valid && rx_cnt_reg == 4'h0 && !irq_take) begin
                        op_reg        <= prog_op;
                        type_reg      <= prog_type;
                        bank_reg      <= prog_bank;
                        val_reg       <= prog_value;
                        csum_ok_reg   <= 1'b1;
                        addr_ok_reg   <= 1'b1;
                        from_host_reg <= 1'b0;
                        rx_ready      <= 1'b0;
                        state_reg     <= cmdx_pkg::ST_EXEC;
                    end
                end
                cmdx_pkg::ST_EXEC: begin
                    rx_cnt_reg <= 4'h0;
                    rx_sum_reg <= 8'h00;
                    // foreign-address frames are dropped without a reply
                    state_reg  <= (from_host_reg && addr_ok_reg) ? cmdx_pkg::ST_TX : cmdx_pkg::ST_RX;
                end
                cmdx_pkg::ST_TX: begin
                    if (tx_step && tx_cnt_reg == cmdx_pkg::POS_CSUM) begin
                        state_reg <= cmdx_pkg::ST_RX;
                    end
                end
                default: state_reg <= cmdx_pkg::ST_RX;
            endcase
        end
    end

    // user variables
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < VAR_NUM; i++) begin
                var_reg[i] <= cmdx_pkg::WORD_RST;
            end
        end else if (exec && exec_ok && (is_vv || is_va)) begin
            if (alu_wr_a) begin
                var_reg[idx_a] <= alu_res;
            end
            // exchange writes the second variable too
            if (alu_wr_b && is_vv) begin
                var_reg[idx_b] <= opnd_a;
            end
        end
    end

    // accumulator, X register, flags and context
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            acc_out       <= cmdx_pkg::WORD_RST;
            x_out         <= cmdx_pkg::WORD_RST;
            flags_out     <= '0;
            sav_acc_reg   <= cmdx_pkg::WORD_RST;
            sav_x_reg     <= cmdx_pkg::WORD_RST;
            sav_flags_reg <= '0;
        end else if (irq_go) begin
            sav_acc_reg   <= acc_out;
            sav_x_reg     <= x_out;
            sav_flags_reg <= flags_out;
        end else if (exec && op_reg == cmdx_pkg::OP_HANDLER_RET && in_handler) begin
            acc_out   <= sav_acc_reg;
            x_out     <= sav_x_reg;
            flags_out <= sav_flags_reg;
        end else begin
            // of the arithmetic commands only the variable-accumulator swap writes acc, ahead of acc_wr
            if (exec && exec_ok && is_va && alu_wr_b) begin
                acc_out <= opnd_a;
            end else if (acc_wr) begin
                acc_out <= acc_wdata;
            end
            if (x_wr) begin
                x_out <= x_wdata;
            end
            if (exec && exec_ok && (is_vv || is_va) && alu_cmp) begin
                flags_out <= alu_flags;
            end
        end
    end

    // handler vectors, global enable and program counter
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < IRQ_NUM; i++) begin
                vec_reg[i] <= cmdx_pkg::WORD_RST;
            end
            irq_enabled <= 1'b0;
            in_handler  <= 1'b0;
            sav_pc_reg  <= cmdx_pkg::WORD_RST;
            pc_out      <= cmdx_pkg::WORD_RST;
            pc_load     <= 1'b0;
        end else begin
            pc_load <= 1'b0;
            if (irq_go) begin
                sav_pc_reg <= pc_in;
                pc_out     <= vec_reg[irq_num[$clog2(IRQ_NUM)-1:0]];
                pc_load    <= 1'b1;
                in_handler <= 1'b1;
            end
            if (exec && op_reg == cmdx_pkg::OP_SET_HANDLER && 32'(type_reg) < IRQ_NUM) begin
                vec_reg[type_reg[$clog2(IRQ_NUM)-1:0]] <= val_reg;
            end
            if (exec && op_reg == cmdx_pkg::OP_HANDLER_RET && in_handler) begin
                pc_out     <= sav_pc_reg;
                pc_load    <= 1'b1;
                in_handler <= 1'b0;
            end
            // number 255 is the global switch
            if (exec && type_reg == cmdx_pkg::IRQ_ALL) begin
                if (op_reg == cmdx_pkg::OP_IRQ_ON) begin
                    irq_enabled <= 1'b1;
                end else if (op_reg == cmdx_pkg::OP_IRQ_OFF) begin
                    irq_enabled <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            status_reg  <= cmdx_pkg::STATUS_OK;
            rep_val_reg <= cmdx_pkg::WORD_RST;
            tx_cnt_reg  <= 4'h0;
            tx_sum_reg  <= 8'h00;
            tx_byte     <= 8'h00;
            tx_valid    <= 1'b0;
            prog_done   <= 1'b0;
        end else begin
            prog_done <= (state_reg == cmdx_pkg::ST_EXEC) && !from_host_reg;
            if (state_reg == cmdx_pkg::ST_EXEC && from_host_reg && addr_ok_reg) begin
                status_reg  <= !csum_ok_reg ? cmdx_pkg::STATUS_BAD_CSUM :
                               exec_ok ? cmdx_pkg::STATUS_OK : cmdx_pkg::STATUS_BAD_CMD;
                rep_val_reg <= (csum_ok_reg && exec_ok && (is_vv || is_va)) ?
                               (alu_wr_a ? alu_res : opnd_a) : cmdx_pkg::WORD_RST;
                tx_cnt_reg  <= 4'h0;
                tx_sum_reg  <= 8'h00;
                tx_byte     <= cmdx_pkg::HOST_ADDR_RST;
                tx_valid    <= 1'b1;
            end else if (tx_step) begin
                // reply checksum is the running sum
                tx_sum_reg <= tx_sum_reg + tx_byte;
                tx_cnt_reg <= tx_cnt_reg + 4'h1;
                if (tx_cnt_reg == cmdx_pkg::POS_CSUM) begin
                    tx_valid <= 1'b0;
                end else if (tx_cnt_reg + 4'h1 == cmdx_pkg::POS_CSUM) begin
                    tx_byte <= tx_sum_reg + tx_byte;
                end else begin
                    tx_byte <= reply_byte(tx_cnt_reg + 4'h1, status_reg, op_reg, rep_val_reg);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/cmd_interp_irq_vector_and_var_arith_bench.sv
// Purpose: self-checking bench of the command execution unit
// Assumes: host frames via host model, program commands driven here
// Notes:   rows cover every operation code across the two arithmetic commands together
`timescale 1ns/1ps
`default_nettype none
module cmd_interp_irq_vector_and_var_arith_bench;
    logic        ref_clk, rst_n, rx_valid, rx_ready, tx_valid, tx_ready, prog_valid, prog_done;
    logic        irq_take, pc_load, irq_enabled, in_handler, acc_wr, x_wr;
    logic [7:0]  rx_byte, tx_byte, prog_op, prog_type, prog_bank, irq_num;
    logic [31:0] prog_value, pc_in, pc_out, acc_wdata, x_wdata, acc_out, x_out;
    logic [1:0]  flags_out;
    int          bad_count = 0, num_checks = 0, i;
    // acc, opcode, type, bank, value, reply value, acc after
    logic [31:0] rows [0:18][0:6] = '{
        '{8'h07, 8'h29, 8'h09, 8'h03, 8'h00, 8'h07, 8'h07}, '{8'h03, 8'h29, 8'h01, 8'h03, 8'h00, 8'h04, 8'h03},
        '{8'h02, 8'h29, 8'h02, 8'h03, 8'h00, 8'h08, 8'h02}, '{8'h03, 8'h29, 8'h03, 8'h03, 8'h00, 8'h02, 8'h03},
        '{8'h14, 8'h29, 8'h09, 8'h04, 8'h00, 8'h14, 8'h14}, '{8'h06, 8'h29, 8'h04, 8'h04, 8'h00, 8'h02, 8'h06},
        '{8'h05, 8'h29, 8'h08, 8'h06, 8'h00, 32'hFFFF_FFFA, 8'h05}, '{8'h09, 8'h29, 8'h0A, 8'h03, 8'h00, 8'h09, 8'h02},
        '{8'h01, 8'h28, 8'h00, 8'h03, 8'h04, 8'h0B, 8'h01}, '{8'h01, 8'h28, 8'h01, 8'h04, 8'h03, 32'hFFFF_FFF7, 8'h01},
        '{8'h01, 8'h28, 8'h09, 8'hFF, 8'h03, 8'h0B, 8'h01}, '{8'h01, 8'h28, 8'h08, 8'h00, 8'hFF, 32'hFFFF_FFF4, 8'h01},
        '{8'h01, 8'h28, 8'h05, 8'hFF, 8'h06, 8'h0A, 8'h01}, '{8'h01, 8'h28, 8'h06, 8'hFF, 8'h04, 32'hFFFF_FFFF, 8'h01},
        '{8'h01, 8'h28, 8'h07, 8'hFF, 8'h06, 8'h05, 8'h01}, '{8'h01, 8'h28, 8'h02, 8'hFF, 8'h04, 32'hFFFF_FFD3, 8'h01},
        '{8'h01, 8'h28, 8'h0A, 8'hFF, 8'h03, 8'h0B, 8'h01}, '{8'h01, 8'h28, 8'h09, 8'h00, 8'h03, 32'hFFFF_FFD3, 8'h01},
        '{8'h01, 8'h28, 8'h0B, 8'h03, 8'h04, 32'hFFFF_FFD3, 8'h01}};
    cmdx_unit DUT (.ref_clk, .rst_n, .rx_byte, .rx_valid, .rx_ready, .tx_byte, .tx_valid, .tx_ready,
        .prog_valid, .prog_op, .prog_type, .prog_bank, .prog_value, .prog_done, .irq_take, .irq_num,
        .pc_in, .pc_out, .pc_load, .irq_enabled, .in_handler, .acc_wr, .acc_wdata, .x_wr, .x_wdata,
        .acc_out, .x_out, .flags_out);
    cmdx_host_model host (.ref_clk, .rx_byte, .rx_valid, .rx_ready, .tx_byte, .tx_valid, .tx_ready);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic set_regs(input logic [31:0] a, input logic [31:0] x);
        {acc_wr, acc_wdata, x_wr, x_wdata} = {1'b1, a, 1'b1, x};
        step();
        {acc_wr, x_wr} = 2'h0;
    endtask
    task automatic frame(input logic [7:0] op, typ, bank, input logic [31:0] val, input logic bad,
                         input logic [7:0] st, input logic [31:0] ev);
        logic [7:0] s;
        s = 8'h00;
        host.send(op, typ, bank, val, bad, op[0]);
        for (int k = 0; k < 8; k++) s += host.rep[k];
        check({host.rep[0], host.rep[1], host.rep[2], host.rep[3]}, {8'h02, 8'h01, st, op});
        check({host.rep[4], host.rep[5], host.rep[6], host.rep[7]}, ev);
        check(host.rep[8], s);
    endtask
    task automatic wait_load();
        for (int n = 0; n < 8 && pc_load !== 1'b1; n++) step();
        check(pc_load, 1'b1);
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (3) step();
        rst_n = 1'b1;
        step();
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        #50000;
        bad_count++;
        finish_test();
    end
    initial begin
        {prog_valid, irq_take, acc_wr, x_wr, irq_num, acc_wdata, x_wdata} = '0;
        {prog_op, prog_type, prog_bank, prog_value, pc_in} = {8'h26, 8'h00, 8'h00, 32'h0, 32'h0000_0123};
        do_reset();
        for (i = 0; i < 19; i++) begin
            set_regs(rows[i][0], 32'h0);
            frame(rows[i][1][7:0], rows[i][2][7:0], rows[i][3][7:0], rows[i][4], 1'b0, 8'h64, rows[i][5]);
            check(acc_out, rows[i][6]);
        end
        check(flags_out, 2'h2);
        frame(8'h25, 8'h00, 8'h00, 32'h50, 1'b0, 8'h64, 32'h0);
        frame(8'h25, 8'h00, 8'h00, 32'h60, 1'b0, 8'h64, 32'h0);
        frame(8'h19, 8'hFF, 8'h00, 32'h0, 1'b0, 8'h64, 32'h0);
        check(irq_enabled, 1'b1);
        frame(8'h29, 8'h0C, 8'h03, 32'h0, 1'b0, 8'h02, 32'h0);
        frame(8'h29, 8'h09, 8'h03, 32'h0, 1'b1, 8'h01, 32'h0);
        frame(8'h28, 8'h09, 8'h00, 32'h3, 1'b0, 8'h64, 32'hFFFF_FFD3);
        frame(8'h26, 8'hFF, 8'h00, 32'h0, 1'b0, 8'h64, 32'h0);
        set_regs(32'hAA, 32'hBB);
        irq_take = 1'b1;
        step();
        irq_take = 1'b0;
        wait_load();
        check(pc_out, 32'h60);
        check(in_handler, 1'b1);
        set_regs(32'h55, 32'h66);
        prog_valid = 1'b1;
        step();
        prog_valid = 1'b0;
        wait_load();
        check(prog_done, 1'b1);
        check(pc_out, 32'h123);
        check(in_handler, 1'b0);
        check(acc_out, 32'hAA);
        check(x_out, 32'hBB);
        check(flags_out, 2'h2);
        frame(8'h1A, 8'hFF, 8'h00, 32'h0, 1'b0, 8'h64, 32'h0);
        check(irq_enabled, 1'b0);
        do_reset();
        check(acc_out, 32'h0);
        check(rx_ready, 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire

// ### testbench/cmdx_host_model.sv
// Purpose: host sending command frames and collecting replies
// Assumes: unit answers every frame addressed to it
// Notes:   released data line shows the inverted last byte
`timescale 1ns/1ps
`default_nettype none
module cmdx_host_model (
    // clock
    input  wire logic       ref_clk,
    // command bytes
    output logic      [7:0] rx_byte,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    // reply bytes
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_valid,
    output logic            tx_ready
);
    logic [7:0] rep [0:8];
    initial begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end
    task automatic send(input logic [7:0] op, typ, bank, input logic [31:0] val, input logic bad, slow);
        logic [7:0] f [0:8];
        int         k;
        f = '{8'h01, op, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
        for (k = 0; k < 8; k++) f[8] += f[k];
        if (bad) f[8] = ~f[8];
        for (k = 0; k < 9; k++) begin
            rx_byte = f[k];
            rx_valid = 1'b1;
            do @(posedge ref_clk); while (rx_ready !== 1'b1);
            #1;
        end
        rx_valid = 1'b0;
        rx_byte = ~rx_byte;
        k = 0;
        // slow mode stalls every other cycle
        while (k < 9) begin
            @(posedge ref_clk);
            if (tx_valid === 1'b1 && tx_ready) begin
                rep[k] = tx_byte;
                k++;
            end
            #1 tx_ready = (k < 9) && (slow ? ~tx_ready : 1'b1);
        end
    endtask
endmodule
`default_nettype wire

// ### testbench/cmdx_unit_chk.sv
// Purpose: port timing checks of the command execution unit
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to every cmdx_unit instance
`timescale 1ns/1ps
`default_nettype none
module cmdx_unit_chk (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // frame handshakes
    input  wire logic       rx_valid,
    input  wire logic       rx_ready,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_valid,
    input  wire logic       tx_ready,
    // handler control
    input  wire logic       pc_load,
    input  wire logic       in_handler
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    a_reply_host_first: assert property ($rose(tx_valid) |-> tx_byte == 8'h02)
        else $error("reply does not open with host address");
    a_tx_byte_stands: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("reply byte changed before taken");
    a_reply_latency: assert property ($rose(tx_valid) |-> $past(rx_valid && rx_ready, 2))
        else $error("reply not two cycles after last byte");
    a_rx_closed_tx: assert property (tx_valid |-> !rx_ready)
        else $error("collector open during reply");
    a_rx_reopens: assert property ($fell(tx_valid) |=> rx_ready)
        else $error("collector not reopened after reply");
    a_pc_load_pulse: assert property (pc_load |=> !pc_load)
        else $error("pc load longer than one cycle");
    a_entry_loads_pc: assert property ($rose(in_handler) |-> pc_load)
        else $error("handler entered without pc load");
    a_return_loads_pc: assert property ($fell(in_handler) |-> pc_load)
        else $error("handler left without pc restore");
endmodule
bind cmdx_unit cmdx_unit_chk u_chk (.ref_clk, .rst_n, .rx_valid, .rx_ready, .tx_byte, .tx_valid,
    .tx_ready, .pc_load, .in_handler);
`default_nettype wire
